/* logic/eas_pkg.sv */
`default_nettype none
package eas_pkg;
  // ************************************************************
  // Access kinds and widths
  // ************************************************************
  typedef enum logic [2:0] {
    EAS_OP_SCALAR = 3'b000,
    EAS_OP_STRING = 3'b001,
    EAS_OP_MULTI  = 3'b010
  } eas_op_e;

  typedef enum logic [1:0] {
    EAS_W1 = 2'b00,
    EAS_W2 = 2'b01,
    EAS_W4 = 2'b10,
    EAS_W8 = 2'b11
  } eas_width_e;

  localparam int          EAS_ADDR_W    = 32;
  localparam int          EAS_DATA_W    = 64;
  localparam logic [2:0]  EAS_SWZ_W8    = 3'h0;
  localparam logic [2:0]  EAS_SWZ_W4    = 3'h4;
  localparam logic [2:0]  EAS_SWZ_W2    = 3'h6;
  localparam logic [2:0]  EAS_SWZ_W1    = 3'h7;
  localparam logic        EAS_BIG_END   = 1'b0;
  localparam logic        EAS_MODE_RST  = 1'b0;

  // ************************************************************
  // Request and memory carriers
  // ************************************************************
  typedef struct packed {
    logic [EAS_ADDR_W-1:0] addr;
    eas_width_e            width;
    eas_op_e               op;
    logic                  write;
    logic [EAS_DATA_W-1:0] wdata;
  } eas_req_s;

  typedef struct packed {
    logic [EAS_ADDR_W-1:0] addr;
    eas_width_e            width;
    logic                  write;
    logic [EAS_DATA_W-1:0] wdata;
  } eas_mem_s;
endpackage
`default_nettype wire

/* logic/eas_swizzle.sv */
// Notes on behaviour
// - Little-endian XORs low address bits by width
// - Modified address and exact width to memory
// - Little-endian misaligned scalar raises alignment fault
// - Little-endian string instructions always fault
// - Little-endian load/store multiple always fault
// - Lowest byte appears at effective address
// - Mode bits: zero big, one little
// - Exception copies exception bit into mode
// - Aligned means address multiple of length
`timescale 1ns/1ns
`default_nettype none
module eas_swizzle (
  input  wire logic              clk_sys_i,        // System clock
  input  wire logic              arst_n_i,         // Async reset, active low
  input  wire logic              req_valid_i,      // Access request strobe
  input  wire eas_pkg::eas_req_s req_i,            // Access request
  input  wire logic              exc_take_i,       // Exception being taken
  input  wire logic              mode_wr_i,        // Mode bits write strobe
  input  wire logic              mode_wdata_i,     // New byte order
  input  wire logic              exc_bo_wdata_i,   // New exception order
  output logic                   mem_valid_o,      // Access to memory
  output eas_pkg::eas_mem_s      mem_o,            // Address, width, data
  output logic                   align_exc_o,      // Alignment fault pulse
  output logic                   byte_swap_mode_o, // Current byte order
  output logic                   exc_byte_order_o  // Exception byte order
);
  import eas_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [2:0] swz_mask(input eas_width_e w);
    case (w)
      EAS_W8:  swz_mask = EAS_SWZ_W8;
      EAS_W4:  swz_mask = EAS_SWZ_W4;
      EAS_W2:  swz_mask = EAS_SWZ_W2;
      default: swz_mask = EAS_SWZ_W1;
    endcase
  endfunction

  function automatic logic misaligned(input eas_width_e w,
                                      input logic [2:0] a);
    case (w)
      EAS_W8:  misaligned = |a;
      EAS_W4:  misaligned = |a[1:0];
      EAS_W2:  misaligned = a[0];
      default: misaligned = 1'b0;
    endcase
  endfunction

  // ************************************************************
  // Mode bits
  // ************************************************************
  logic byte_swap_mode;
  logic exc_byte_order;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byte_swap_mode <= EAS_MODE_RST;
      exc_byte_order <= EAS_MODE_RST;
    end else if (exc_take_i) begin
      byte_swap_mode <= exc_byte_order;
    end else if (mode_wr_i) begin
      byte_swap_mode <= mode_wdata_i;
      exc_byte_order <= exc_bo_wdata_i;
    end
  end

  // ************************************************************
  // Address stage
  // ************************************************************
  logic       little;
  logic       fault;
  logic [2:0] next_low;

  always_comb begin
    little = (byte_swap_mode != EAS_BIG_END);
    fault  = 1'b0;
    next_low = req_i.addr[2:0];
    if (little) begin
      next_low = req_i.addr[2:0] ^ swz_mask(req_i.width);
      if (req_i.op == EAS_OP_STRING) begin
        fault = 1'b1;
      end else if (req_i.op == EAS_OP_MULTI) begin
        fault = 1'b1;
      end else begin
        fault = misaligned(req_i.width, req_i.addr[2:0]);
      end
    end
    // big-endian leaves address and checks untouched
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_valid_o <= 1'b0;
      align_exc_o <= 1'b0;
      mem_o       <= '0;
    end else begin
      mem_valid_o <= req_valid_i && !fault;
      align_exc_o <= req_valid_i && fault;
      if (req_valid_i && !fault) begin
        mem_o.addr  <= {req_i.addr[EAS_ADDR_W-1:3], next_low};
        mem_o.width <= req_i.width;
        mem_o.write <= req_i.write;
        mem_o.wdata <= req_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byte_swap_mode_o <= EAS_MODE_RST;
      exc_byte_order_o <= EAS_MODE_RST;
    end else begin
      byte_swap_mode_o <= byte_swap_mode;
      exc_byte_order_o <= exc_byte_order;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  le_xor_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && !fault |=> mem_valid_o &&
      mem_o.addr[2:0] == ($past(req_i.addr[2:0]) ^
                          swz_mask($past(req_i.width))))
    else $error("swizzled address wrong");

  be_pass_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && !little |=> mem_valid_o && !align_exc_o &&
      mem_o.addr == $past(req_i.addr))
    else $error("big-endian address altered");

  str_exc_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_STRING |=> align_exc_o)
    else $error("string access not faulted");

  mul_exc_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_MULTI |=> align_exc_o)
    else $error("multiple access not faulted");

  mis_exc_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_SCALAR &&
      req_i.width == EAS_W4 && req_i.addr[1:0] != 2'h0 |=> align_exc_o)
    else $error("misaligned word not faulted");

  exc_mode_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    exc_take_i |=> byte_swap_mode == $past(exc_byte_order))
    else $error("mode not copied on exception");

  one_out_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    !(mem_valid_o && align_exc_o))
    else $error("fault and access together");

  w8_keep_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_SCALAR &&
      req_i.width == EAS_W8 && req_i.addr[2:0] == 3'h0 |=>
      mem_valid_o && mem_o.addr == $past(req_i.addr))
    else $error("double word address altered");

  w4_xor_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_SCALAR &&
      req_i.width == EAS_W4 && req_i.addr[1:0] == 2'h0 |=>
      mem_valid_o && mem_o.addr[2:0] == ($past(req_i.addr[2:0]) ^ EAS_SWZ_W4))
    else $error("word address not swizzled");

  w2_xor_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_SCALAR &&
      req_i.width == EAS_W2 && !req_i.addr[0] |=>
      mem_valid_o && mem_o.addr[2:0] == ($past(req_i.addr[2:0]) ^ EAS_SWZ_W2))
    else $error("half word address not swizzled");

  w1_xor_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_SCALAR &&
      req_i.width == EAS_W1 |=>
      mem_valid_o && mem_o.addr[2:0] == ($past(req_i.addr[2:0]) ^ EAS_SWZ_W1))
    else $error("byte address not swizzled");

  hi_keep_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && !fault |=>
      mem_o.addr[EAS_ADDR_W-1:3] == $past(req_i.addr[EAS_ADDR_W-1:3]))
    else $error("upper address bits altered");

  data_pass_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && !fault |=> mem_o.width == $past(req_i.width) &&
      mem_o.write == $past(req_i.write) &&
      mem_o.wdata == $past(req_i.wdata))
    else $error("width or data not passed");

  hw_mis_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_SCALAR &&
      req_i.width == EAS_W2 && req_i.addr[0] |=> align_exc_o)
    else $error("misaligned half word not faulted");

  dw_mis_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_valid_i && little && req_i.op == EAS_OP_SCALAR &&
      req_i.width == EAS_W8 && req_i.addr[2:0] != 3'h0 |=> align_exc_o)
    else $error("misaligned double word not faulted");

  mode_wr_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    mode_wr_i && !exc_take_i |=> byte_swap_mode == $past(mode_wdata_i) &&
      exc_byte_order == $past(exc_bo_wdata_i))
    else $error("mode bits not loaded");

  exc_keep_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    exc_take_i |=> exc_byte_order == $past(exc_byte_order))
    else $error("exception bit changed on exception");

  no_req_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    !req_valid_i |=> !mem_valid_o && !align_exc_o)
    else $error("output without request");

  mem_hold_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    !(req_valid_i && !fault) |=> $stable(mem_o))
    else $error("memory request changed while idle");

  mode_out_a: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    byte_swap_mode_o == $past(byte_swap_mode) &&
      exc_byte_order_o == $past(exc_byte_order))
    else $error("mode outputs do not follow");
endmodule
`default_nettype wire

/* bench/eas_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module eas_mem_model (
  input  wire logic              clk_sys_i,    // System clock
  input  wire logic              arst_n_i,     // Async reset, active low
  input  wire logic              mem_valid_i,  // Access strobe from the block
  input  wire eas_pkg::eas_mem_s mem_i,        // Address, width, data
  output logic [7:0]             n_acc_o,      // Accesses accepted so far
  output logic [7:0]             n_wr_o        // Write accesses so far
);
  import eas_pkg::*;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      n_acc_o <= 8'h00;
      n_wr_o  <= 8'h00;
    end else if (mem_valid_i) begin
      n_acc_o <= n_acc_o + 8'h01;
      if (mem_i.write) begin
        n_wr_o <= n_wr_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/eas_swizzle_test.sv */
`timescale 1ns/1ns
`default_nettype none
module eas_swizzle_test;
  import eas_pkg::*;
  logic clk_sys_i, arst_n_i, req_valid_i, exc_take_i, mode_wr_i;
  logic mode_wdata_i, exc_bo_wdata_i, mem_valid_o, align_exc_o;
  logic byte_swap_mode_o, exc_byte_order_o;
  logic [7:0] n_acc, n_wr;
  eas_req_s req_i;
  eas_mem_s mem_o;
  int mismatches, n_compared;
  eas_swizzle uut (.clk_sys_i, .arst_n_i, .req_valid_i, .req_i,
    .exc_take_i, .mode_wr_i, .mode_wdata_i, .exc_bo_wdata_i, .mem_valid_o,
    .mem_o, .align_exc_o, .byte_swap_mode_o, .exc_byte_order_o);
  eas_mem_model mem (.clk_sys_i, .arst_n_i, .mem_valid_i(mem_valid_o),
    .mem_i(mem_o), .n_acc_o(n_acc), .n_wr_o(n_wr));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic setm(input logic m, input logic x);
    @(posedge clk_sys_i) #1;
    {mode_wr_i, mode_wdata_i, exc_bo_wdata_i} = {1'b1, m, x};
    @(posedge clk_sys_i) #1 mode_wr_i = 1'b0;
  endtask
  task automatic acc(input logic [31:0] a, input eas_width_e w,
                     input eas_op_e o, input logic ex, input logic [31:0] ea);
    @(posedge clk_sys_i) #1;
    req_i = '{a, w, o, a[0], {a, ~a}};
    req_valid_i = 1'b1;
    @(posedge clk_sys_i) #1 req_valid_i = 1'b0;
    chk(align_exc_o, ex);
    chk(mem_valid_o, !ex);
    if (!ex) begin
      chk(mem_o.addr, ea);
      chk(mem_o.width, w);
      chk(mem_o.write, a[0]);
      chk(mem_o.wdata, {a, ~a});
    end
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_little();
    setm(1'b1, 1'b0);
    acc(32'h100, EAS_W8, EAS_OP_SCALAR, 1'b0, 32'h100);
    acc(32'h104, EAS_W4, EAS_OP_SCALAR, 1'b0, 32'h100);
    acc(32'h106, EAS_W2, EAS_OP_SCALAR, 1'b0, 32'h100);
    acc(32'h005, EAS_W1, EAS_OP_SCALAR, 1'b0, 32'h002);
  endtask
  task automatic t_misalign();
    acc(32'h006, EAS_W4, EAS_OP_SCALAR, 1'b1, 32'h0);
    acc(32'h003, EAS_W2, EAS_OP_SCALAR, 1'b1, 32'h0);
    acc(32'h004, EAS_W8, EAS_OP_SCALAR, 1'b1, 32'h0);
    acc(32'h003, EAS_W1, EAS_OP_SCALAR, 1'b0, 32'h4);
  endtask
  task automatic t_strmul();
    acc(32'h000, EAS_W4, EAS_OP_STRING, 1'b1, 32'h0);
    acc(32'h008, EAS_W4, EAS_OP_MULTI, 1'b1, 32'h0);
  endtask
  task automatic t_big();
    setm(1'b0, 1'b1);
    @(posedge clk_sys_i) #1;
    chk({byte_swap_mode_o, exc_byte_order_o}, 2'b01);
    acc(32'h005, EAS_W1, EAS_OP_SCALAR, 1'b0, 32'h005);
    acc(32'h006, EAS_W4, EAS_OP_SCALAR, 1'b0, 32'h006);
    acc(32'h006, EAS_W4, EAS_OP_STRING, 1'b0, 32'h006);
  endtask
  task automatic t_exc();
    @(posedge clk_sys_i) #1 exc_take_i = 1'b1;
    @(posedge clk_sys_i) #1 exc_take_i = 1'b0;
    @(posedge clk_sys_i) #1 chk(byte_swap_mode_o, 1'b1);
    acc(32'h000, EAS_W1, EAS_OP_SCALAR, 1'b0, 32'h007);
    @(posedge clk_sys_i) #1 chk(n_acc, 8'h09);
    chk(n_wr, 8'h03);
  endtask
  task automatic t_rst();
    @(posedge clk_sys_i) #1 arst_n_i = 1'b0;
    #2 chk({byte_swap_mode_o, exc_byte_order_o}, 2'b00);
    chk({mem_valid_o, align_exc_o}, 2'b00);
    chk(mem_o.addr, 32'h0);
    @(posedge clk_sys_i) #1 arst_n_i = 1'b1;
    chk(n_acc, 8'h00);
    acc(32'h006, EAS_W2, EAS_OP_SCALAR, 1'b0, 32'h006);
    @(posedge clk_sys_i) #1 chk(n_acc, 8'h01);
  endtask
  initial begin
    {arst_n_i, req_valid_i, exc_take_i, mode_wr_i} = 4'h0;
    {mode_wdata_i, exc_bo_wdata_i} = 2'b00;
    req_i = '0;
    repeat (4) @(posedge clk_sys_i);
    #1 arst_n_i = 1'b1;
    t_little();
    t_misalign();
    t_strmul();
    t_big();
    t_exc();
    t_rst();
    complete_run();
  end
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
